// file: design/iowdt_pkg.sv
/*
  types of the i/o port watchdog.
  assumes iowdt_regs.svh is reachable on the include path.
*/
package iowdt_pkg;
  // watchdog state, one-hot
  typedef enum logic [2:0]
  {
    IOWDT_IDLE  = 3'b001,
    IOWDT_ARMED = 3'b010,
    IOWDT_FIRE  = 3'b100
  } iowdt_state_t;
endpackage : iowdt_pkg

// file: design/iowdt_regs.svh
/*
  constants of the i/o port watchdog: port addresses, timebase and reset values.
  assumes a 40 MHz clock and a 16-bit i/o address from the host.
*/
`ifndef IOWDT_REGS_SVH
`define IOWDT_REGS_SVH

// ==========================================================
// port addresses
`define IOWDT_ARM_PORT      16'h0443
`define IOWDT_DISARM_PORT_A 16'h0043
`define IOWDT_DISARM_PORT_B 16'h0843

// ==========================================================
// timing
`define IOWDT_CLOCK_HZ      32'h0262_5A00
`define IOWDT_SECOND_S      32'h0000_0001
`define IOWDT_TICKS_PER_SEC (`IOWDT_CLOCK_HZ * `IOWDT_SECOND_S)

// ==========================================================
// reset values and limits
`define IOWDT_PERIOD_RESET  8'h01
`define IOWDT_PERIOD_MIN    8'h01
`define IOWDT_RST_PULSE     8'h10

`endif

// file: design/iowdt_sec_tick.sv
/*
  seconds timebase: a free counter giving one pulse per second.
  assumes a synchronous active-high restart from the watchdog.
*/
`timescale 1ns/1ps
`include "iowdt_regs.svh"

module iowdt_sec_tick
#(
  parameter int unsigned TICKS = `IOWDT_TICKS_PER_SEC
)
(
  input  wire logic clock,
  input  wire logic srst,
  input  wire logic restart,
  output logic      tick
);
  import iowdt_pkg::*;

  // ==========================================================
  // state
  typedef struct packed
  {
    logic [31:0] cnt;   // cycles into the current second
    logic        tick;  // registered one-cycle tick
  } iowdt_tick_st_t;

  iowdt_tick_st_t s_q;
  iowdt_tick_st_t s_d;

  // next-state: count, wrap and flag the end of each second
  always_comb
  begin
    s_d      = s_q;
    s_d.tick = 1'b0;
    if (restart)
    begin
      s_d.cnt = 32'h0;
    end
    else if (s_q.cnt == TICKS - 1)
    begin
      s_d.cnt  = 32'h0;
      s_d.tick = 1'b1;
    end
    else
    begin
      s_d.cnt = s_q.cnt + 32'h1;
    end
  end

  // registers
  always_ff @(posedge clock)
  begin
    if (srst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign tick = s_q.tick;

  // tick never comes early after restart
  tick_spacing_a : assert property (@(posedge clock) disable iff (srst)
    restart |=> !tick [*2])
    else $error("tick too soon after restart");
endmodule : iowdt_sec_tick

// file: design/iowdt_top.sv
/*
  i/o port watchdog: armed by host reads of the arm port, disarmed by reads
  of either disarm port, counts whole seconds and pulses a system reset.
  assumes host read strobes are one-cycle pulses synchronous to clock.
*/
`timescale 1ns/1ps
`include "iowdt_regs.svh"

module iowdt_top
#(
  parameter int unsigned TICKS_PER_SEC = `IOWDT_TICKS_PER_SEC
)
(
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic [15:0] io_addr,
  input  wire logic        io_rd,
  input  wire logic [7:0]  period_sec,
  input  wire logic        timeout_action_strap,
  output logic             sys_reset,
  output logic             armed,
  output logic [7:0]       remaining_sec
);
  import iowdt_pkg::*;

  // ==========================================================
  // state
  typedef struct packed
  {
    iowdt_state_t st;     // control state
    logic [7:0]   left;   // whole seconds remaining
    logic [7:0]   pulse;  // reset pulse cycles remaining
    logic         rst;    // registered reset output
  } iowdt_top_st_t;

  iowdt_top_st_t s_q;
  iowdt_top_st_t s_d;

  logic          arm_rd;     // read of the arm port
  logic          disarm_rd;  // read of either disarm port
  logic          tick;       // one pulse per second
  logic [7:0]    load_val;   // period clamped to at least one second

  // ==========================================================
  // address decode
  assign arm_rd    = io_rd && (io_addr == `IOWDT_ARM_PORT);
  assign disarm_rd = io_rd && ((io_addr == `IOWDT_DISARM_PORT_A) ||
                               (io_addr == `IOWDT_DISARM_PORT_B));
  // zero would mean no period at all, so it counts as one second
  assign load_val  = (period_sec < `IOWDT_PERIOD_MIN) ? `IOWDT_PERIOD_MIN
                                                      : period_sec;

  // ==========================================================
  // seconds timebase, restarted on every arm or retrigger
  iowdt_sec_tick #(.TICKS(TICKS_PER_SEC)) u_tick
  (
    .clock   (clock),
    .srst    (srst),
    .restart (arm_rd),
    .tick    (tick)
  );

  // next-state logic
  always_comb
  begin
    s_d     = s_q;
    s_d.rst = 1'b0;
    unique case (s_q.st)
      IOWDT_IDLE:
      begin
        if (arm_rd && !disarm_rd)
        begin
          s_d.st   = IOWDT_ARMED;
          s_d.left = load_val;
        end
      end
      IOWDT_ARMED:
      begin
        if (disarm_rd)
        begin
          s_d.st   = IOWDT_IDLE;
          s_d.left = 8'h00;
        end
        else if (arm_rd)
        begin
          s_d.left = load_val;
        end
        else if (tick)
        begin
          if (s_q.left == 8'h01)
          begin
            s_d.left = 8'h00;
            // strap high = 2-3 position = reset; low = reserved, no action
            if (timeout_action_strap)
            begin
              s_d.st    = IOWDT_FIRE;
              s_d.pulse = `IOWDT_RST_PULSE;
            end
            else
            begin
              s_d.st = IOWDT_IDLE;
            end
          end
          else
          begin
            s_d.left = s_q.left - 8'h01;
          end
        end
      end
      IOWDT_FIRE:
      begin
        // reset pulse runs to completion, then the watchdog rests disarmed
        s_d.rst   = 1'b1;
        s_d.pulse = s_q.pulse - 8'h01;
        if (s_q.pulse == 8'h01)
          s_d.st = IOWDT_IDLE;
      end
      default:
      begin
        s_d.st = IOWDT_IDLE;
      end
    endcase
  end

  // registers
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      s_q.st    <= IOWDT_IDLE;
      s_q.left  <= 8'h00;
      s_q.pulse <= 8'h00;
      s_q.rst   <= 1'b0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // outputs
  assign sys_reset     = s_q.rst;
  assign armed         = (s_q.st == IOWDT_ARMED);
  assign remaining_sec = s_q.left;

  // ==========================================================
  // checks

  // an accepted arm read leaves the watchdog armed with the new period
  arm_read_a : assert property (@(posedge clock) disable iff (srst)
    (arm_rd && !disarm_rd && s_q.st != IOWDT_FIRE)
      |=> armed && remaining_sec == $past(load_val))
    else $error("arm read did not arm or reload");

  // the watchdog only arms on a read, never by itself
  arm_source_a : assert property (@(posedge clock) disable iff (srst)
    $rose(armed) |-> $past(arm_rd))
    else $error("armed without an arm read");

  // a disarm read stops the count and keeps the reset line low
  disarm_read_a : assert property (@(posedge clock) disable iff (srst)
    (disarm_rd && s_q.st != IOWDT_FIRE) |=> !armed ##1 !sys_reset)
    else $error("disarm read did not stop watchdog");

  // a disarm read also clears the seconds left
  disarm_clear_a : assert property (@(posedge clock) disable iff (srst)
    (disarm_rd && s_q.st != IOWDT_FIRE) |=> remaining_sec == 8'h00)
    else $error("disarm read left seconds behind");

  // a retrigger reloads the full period
  retrigger_reload_a : assert property (@(posedge clock) disable iff (srst)
    (armed && arm_rd && !disarm_rd) |=> remaining_sec == $past(load_val))
    else $error("retrigger did not reload");

  // the last second running out with the reset strap gives a reset
  expiry_reset_a : assert property (@(posedge clock) disable iff (srst)
    (armed && tick && remaining_sec == 8'h01 && !io_rd && timeout_action_strap)
      |=> ##1 sys_reset [*8])
    else $error("expiry did not assert reset");

  // the reset pulse is still high after its last count and then drops
  reset_end_a : assert property (@(posedge clock) disable iff (srst)
    (s_q.st == IOWDT_FIRE && s_q.pulse == 8'h01) |=> sys_reset ##1 !sys_reset)
    else $error("reset pulse did not end");

  // host reads while in the firing state are refused
  fire_refuse_a : assert property (@(posedge clock) disable iff (srst)
    (s_q.st == IOWDT_FIRE && io_rd) |=> !armed)
    else $error("read accepted during reset pulse");

  // the reserved strap position disarms quietly on expiry
  strap_reserved_a : assert property (@(posedge clock) disable iff (srst)
    (armed && tick && remaining_sec == 8'h01 && !io_rd && !timeout_action_strap)
      |=> !armed ##1 !sys_reset)
    else $error("reserved strap gave a reset");

  // a reset pulse only ever starts from the firing state
  reset_cause_a : assert property (@(posedge clock) disable iff (srst)
    $rose(sys_reset) |-> $past(s_q.st) == IOWDT_FIRE)
    else $error("reset pulse without expiry");

  // an armed watchdog always has at least one second left
  period_range_a : assert property (@(posedge clock) disable iff (srst)
    armed |-> remaining_sec != 8'h00)
    else $error("armed with zero seconds");

  // a zero period loads as one second
  zero_clamp_a : assert property (@(posedge clock) disable iff (srst)
    (arm_rd && !disarm_rd && s_q.st != IOWDT_FIRE && period_sec == 8'h00)
      |=> remaining_sec == 8'h01)
    else $error("zero period not clamped");

  // a watchdog in the idle state never drives the reset line in the next cycle
  idle_quiet_a : assert property (@(posedge clock) disable iff (srst)
    (s_q.st == IOWDT_IDLE) |=> !sys_reset)
    else $error("reset while disarmed");

  // each second tick takes one off the count
  count_step_a : assert property (@(posedge clock) disable iff (srst)
    (armed && tick && !io_rd && remaining_sec > 8'h01)
      |=> remaining_sec == $past(remaining_sec) - 8'h01)
    else $error("seconds count did not step");
endmodule : iowdt_top

// file: sim/io_port_watchdog_timer_tb_top.sv
/*
  testbench of the i/o port watchdog, shortened seconds timebase.
  assumes iowdt_host_model drives the host read cycles.
*/
`timescale 1ns/1ps

module io_port_watchdog_timer_tb_top;
  localparam int TPS = 20; // clocks per simulated second
  logic        clock;
  logic        srst;
  logic        strap;
  logic [7:0]  period;
  logic [15:0] io_addr;
  logic        io_rd;
  logic        sys_reset;
  logic        armed;
  logic [7:0]  remaining_sec;
  int          failures;
  int          n_checks;
  int          cycles;

  // ==========================================
  // clock and hang guard
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      failures++;
      print_verdict();
    end
  end

  iowdt_host_model host_u (.clock(clock), .io_addr(io_addr), .io_rd(io_rd));
  iowdt_top #(.TICKS_PER_SEC(TPS)) dut_u (.clock(clock), .srst(srst),
    .io_addr(io_addr), .io_rd(io_rd), .period_sec(period),
    .timeout_action_strap(strap), .sys_reset(sys_reset), .armed(armed),
    .remaining_sec(remaining_sec));

  // ==========================================
  // helpers
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step
  // count the cycles with the system reset high over a window
  task automatic watch_reset(input int n, output int hits);
    hits = 0;
    repeat (n)
    begin
      step(1);
      if (sys_reset !== 1'b0)
        hits++;
    end
  endtask : watch_reset
  task automatic arm(input logic [7:0] p, input logic [15:0] a);
    @(posedge clock);
    period <= p;
    host_u.read_port(a);
    step(1);
  endtask : arm
  task print_verdict;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : print_verdict

  // ==========================================
  // scenarios
  task automatic t_expire;
    int n;
    arm(8'h02, 16'h0443);
    check("armed", armed, 8'h01);
    check("remaining", remaining_sec, 8'h02);
    n = 1;
    while (sys_reset !== 1'b1 && n < 60)
    begin
      step(1);
      n++;
    end
    check("expiry time", 8'(n), 8'(2 * TPS + 2));
    // an arm read in the middle of the pulse must be refused
    host_u.read_port(16'h0443);
    step(1);
    n = 0;
    while (sys_reset === 1'b1 && n < 40)
    begin
      step(1);
      n++;
    end
    // 16-cycle pulse less the 3 cycles spent on the refused read
    check("reset width", 8'(n), 8'h0D);
    check("armed after", armed, 8'h00);
  endtask : t_expire
  task automatic t_retrigger;
    int hits;
    arm(8'h03, 16'h0443);
    step(30);
    check("count down", remaining_sec, 8'h02);
    arm(8'h03, 16'h0443);
    check("reload", remaining_sec, 8'h03);
    watch_reset(50, hits);
    check("no early reset", 8'(hits), 8'h00);
    arm(8'h03, 16'h0043);
    check("disarm a", armed, 8'h00);
    watch_reset(80, hits);
    check("quiet a", 8'(hits), 8'h00);
  endtask : t_retrigger
  task automatic t_ports;
    arm(8'h05, 16'h0444);
    check("other port", armed, 8'h00);
    arm(8'hFF, 16'h0443);
    check("max period", remaining_sec, 8'hFF);
    arm(8'hFF, 16'h0843);
    check("disarm b", armed, 8'h00);
    check("disarm rem", remaining_sec, 8'h00);
  endtask : t_ports
  task automatic t_strap;
    int n;
    @(posedge clock);
    strap <= 1'b0;
    arm(8'h00, 16'h0443);
    check("zero period", remaining_sec, 8'h01);
    watch_reset(40, n);
    check("reserved no reset", 8'(n), 8'h00);
    check("reserved disarm", armed, 8'h00);
    @(posedge clock);
    strap <= 1'b1;
  endtask : t_strap

  // ==========================================
  // main sequence
  initial
  begin
    srst   = 1'b1;
    strap  = 1'b1;
    period = 8'h01;
    repeat (3) @(posedge clock);
    srst <= 1'b0;
    step(1);
    check("reset out", {sys_reset, armed}, 8'h00);
    check("reset rem", remaining_sec, 8'h00);
    t_expire();
    t_retrigger();
    t_ports();
    t_strap();
    print_verdict();
  end
endmodule : io_port_watchdog_timer_tb_top

// file: sim/iowdt_host_model.sv
/*
  host model: issues i/o port read cycles toward the watchdog.
  assumes the bench clock; the address is scrambled once the strobe drops.
*/
`timescale 1ns/1ps

module iowdt_host_model
(
  input  wire logic        clock,
  output logic      [15:0] io_addr,
  output logic             io_rd
);
  // ==========================================
  // idle levels
  initial
  begin
    io_addr = 16'h0000;
    io_rd   = 1'b0;
  end

  // ==========================================
  // one-cycle read strobe, used for arm, retrigger and disarm
  task automatic read_port(input logic [15:0] a);
    @(posedge clock);
    io_rd   <= 1'b1;
    io_addr <= a;
    @(posedge clock);
    io_rd   <= 1'b0;
    io_addr <= ~a; // no stale address after release
  endtask : read_port
endmodule : iowdt_host_model
